/* core/sesf_pkg.sv */
// Purpose: Shared constants and types of the supply event status flags
// Assumes: One system clock, asynchronous active-high reset
// Notes:   Flag bits 10 down to 5 of the status word are contiguous
`default_nettype none

package sesf_pkg;
    // ------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------
    localparam int          FRAME_BITS = 32;
    localparam int          CMD_BITS   = 7;
    localparam int          ADDR_W     = 6;
    localparam int          CNT_W      = 6;
    localparam int          REG_W      = 24;
    localparam logic [5:0]  CNT_MAX    = 6'h3f;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0]  OFS_STATUS   = 6'h00;
    localparam logic [5:0]  OFS_CHECKSUM = 6'h03;

    // ------------------------------------------------------------
    // Flag layout, indices inside the flag vector
    // ------------------------------------------------------------
    localparam int          FLAG_N   = 6;
    localparam int          FLAG_LSB = 5;
    localparam int          F_WIN1   = 5;
    localparam int          F_WIN0   = 4;
    localparam int          F_CK     = 3;
    localparam int          F_LOW    = 2;
    localparam int          F_HIGH   = 1;
    localparam int          F_TW     = 0;
    localparam logic [5:0]  FLAGS_RST = 6'h00;

    // ------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------
    localparam int          PIN_N  = 6;
    localparam int          P_CS   = 5;
    localparam int          P_SCLK = 4;
    localparam int          P_SI   = 3;
    localparam int          P_LOW  = 2;
    localparam int          P_HIGH = 1;
    localparam int          P_TW   = 0;
    localparam logic [5:0]  PIN_IDLE = 6'h20;

    // ------------------------------------------------------------
    // Checksum engine
    // ------------------------------------------------------------
    localparam int          CK_W    = 8;
    localparam int          CK_LEN  = 32;
    localparam logic [7:0]  CK_POLY = 8'h07;
    localparam logic [7:0]  CK_INIT = 8'h00;

    typedef enum logic [1:0] {
        SESF_CK_IDLE = 2'b01,
        SESF_CK_RUN  = 2'b10
    } sesf_ck_state_t;
endpackage : sesf_pkg

`default_nettype wire

/* core/sesf_flag_if.sv */
// Purpose: Set, clear and state of the event flags between modules
// Assumes: All signals on the system clock
// Notes:   Set wins over clear in the flag bank
`default_nettype none

interface sesf_flag_if;
    logic [sesf_pkg::FLAG_N-1:0] set;
    logic [sesf_pkg::FLAG_N-1:0] clr;
    logic [sesf_pkg::FLAG_N-1:0] flags;

    modport producer (output set, output clr, input flags);
    modport bank     (input set, input clr, output flags);
endinterface : sesf_flag_if

`default_nettype wire

/* core/sesf_flag_bank.sv */
// Purpose: Sticky read-to-clear event flags
// Assumes: set and clr are one-cycle masks
// Notes:   A set in the clear cycle keeps the flag
`default_nettype none

module sesf_flag_bank (
    // Clock and reset
    input  wire logic    i_sys_clk,
    input  wire logic    i_rst,
    // Flag traffic
    sesf_flag_if.bank    flag_io
);
    logic [sesf_pkg::FLAG_N-1:0] flags_reg;
    logic [sesf_pkg::FLAG_N-1:0] flags_next;

    assign flags_next    = (flags_reg & ~flag_io.clr) | flag_io.set; // R9
    assign flag_io.flags = flags_reg;

    genvar g;
    generate
        for (g = 0; g < sesf_pkg::FLAG_N; g++) begin : g_flag
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    flags_reg[g] <= sesf_pkg::FLAGS_RST[g];
                end else begin
                    flags_reg[g] <= flags_next[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    set_wins_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (flag_io.set != '0) |=> ((flags_reg & $past(flag_io.set)) == $past(flag_io.set))) // R9
        else $error("flag set lost");
    clear_done_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (flag_io.clr != '0) |=> ((flags_reg & $past(flag_io.clr) & ~$past(flag_io.set)) == '0)) // R9
        else $error("flag not cleared");
endmodule : sesf_flag_bank

`default_nettype wire

/* core/sesf_core.sv */
// Purpose: Supply, checksum and thermal event flags with serial status read
// Assumes: Analog condition pins and serial pins are asynchronous
// Notes:   Frame is rw bit, 6 address bits, 24 data bits, one unchecked trailing bit
//
// Behaviour
// R1: With measurement active, supply crossing either window-1 threshold sets its flag.
// R2: With measurement active, supply crossing either window-0 threshold sets its flag.
// R3: Finished checksum calculation sets the checksum-done flag.
// R4: Checksum-done reads zero while running, before start, or after read.
// R5: Finished checksum result is readable at checksum register offset.
// R6: Under-voltage start and end both set the supply-low flag.
// R7: Over-voltage start and end both set the supply-high flag.
// R8: Thermal warning start and end both set the thermal-warn flag.
// R9: Reading the status register clears the reported flags.
// R10: Interrupt releases at chip-select rise ending the status read.
// R11: Interrupt output asserted low while any flag is set.
`default_nettype none

module sesf_core #(
    parameter int LVL_W = 10
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    // Serial port
    input  wire logic             i_cs_n,
    input  wire logic             i_sclk,
    input  wire logic             i_si,
    output logic                  o_so,
    output logic                  o_so_oe,
    // Supply measurement
    input  wire logic             i_meas_active,
    input  wire logic [LVL_W-1:0] i_supply_level,
    input  wire logic [LVL_W-1:0] i_window0_threshold_a,
    input  wire logic [LVL_W-1:0] i_window0_threshold_b,
    input  wire logic [LVL_W-1:0] i_window1_threshold_a,
    input  wire logic [LVL_W-1:0] i_window1_threshold_b,
    // Condition pins
    input  wire logic             i_supply_low,
    input  wire logic             i_supply_high,
    input  wire logic             i_thermal_warn,
    // Checksum
    input  wire logic             i_checksum_start,
    input  wire logic [31:0]      i_checksum_word,
    // Interrupt
    output logic                  o_int_n
);
    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] thr_state(input logic [LVL_W-1:0] lvl, input logic [LVL_W-1:0] ta,
                                             input logic [LVL_W-1:0] tb);
        thr_state = {lvl >= ta, lvl >= tb};
    endfunction : thr_state
    function automatic logic [sesf_pkg::REG_W-1:0] rd_mux(input logic [5:0] addr,
                                                         input logic [5:0] flg,
                                                         input logic [7:0] ck);
        rd_mux = '0;
        if (addr == sesf_pkg::OFS_STATUS) begin
            rd_mux[sesf_pkg::FLAG_LSB +: sesf_pkg::FLAG_N] = flg;
        end else if (addr == sesf_pkg::OFS_CHECKSUM) begin
            rd_mux[sesf_pkg::CK_W-1:0] = ck; // R5
        end
    endfunction : rd_mux

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [sesf_pkg::PIN_N-1:0] pin_raw;
    logic [sesf_pkg::PIN_N-1:0] s1_reg;
    logic [sesf_pkg::PIN_N-1:0] s2_reg;
    logic [sesf_pkg::PIN_N-1:0] s3_reg;
    assign pin_raw = {i_cs_n, i_sclk, i_si, i_supply_low, i_supply_high, i_thermal_warn};
    genvar g;
    generate
        for (g = 0; g < sesf_pkg::PIN_N; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    s1_reg[g] <= sesf_pkg::PIN_IDLE[g];
                    s2_reg[g] <= sesf_pkg::PIN_IDLE[g];
                    s3_reg[g] <= sesf_pkg::PIN_IDLE[g];
                end else begin
                    s1_reg[g] <= pin_raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                end
            end
        end
    endgenerate
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic si_bit;
    assign cs_low    = ~s2_reg[sesf_pkg::P_CS];
    assign cs_fall   = ~s2_reg[sesf_pkg::P_CS] & s3_reg[sesf_pkg::P_CS];
    assign cs_rise   = s2_reg[sesf_pkg::P_CS] & ~s3_reg[sesf_pkg::P_CS];
    assign sclk_rise = cs_low & s2_reg[sesf_pkg::P_SCLK] & ~s3_reg[sesf_pkg::P_SCLK];
    assign sclk_fall = cs_low & ~s2_reg[sesf_pkg::P_SCLK] & s3_reg[sesf_pkg::P_SCLK];
    assign si_bit    = s2_reg[sesf_pkg::P_SI];

    // ------------------------------------------------------------
    // Flag bank
    // ------------------------------------------------------------
    sesf_flag_if flag_bus ();
    sesf_flag_bank u_bank (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .flag_io   (flag_bus.bank)
    );

    // ------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------
    logic [sesf_pkg::CNT_W-1:0]      bit_cnt_reg;
    logic [sesf_pkg::FRAME_BITS-1:0] rx_reg;
    logic [sesf_pkg::REG_W-1:0]      tx_reg;
    logic [sesf_pkg::FLAG_N-1:0]     snap_reg;
    logic [sesf_pkg::ADDR_W-1:0]     cmd_addr;
    logic                            cmd_load;
    logic                            tx_shift;
    logic                            frame_ok;
    logic                            status_read;
    logic [sesf_pkg::FLAG_N-1:0]     read_clr;
    logic [sesf_pkg::CK_W-1:0]       ck_result_reg;
    assign cmd_addr    = {rx_reg[sesf_pkg::ADDR_W-2:0], si_bit};
    assign cmd_load    = sclk_rise && (bit_cnt_reg == sesf_pkg::CNT_W'(sesf_pkg::CMD_BITS - 1));
    assign tx_shift    = sclk_fall && (bit_cnt_reg >= sesf_pkg::CNT_W'(sesf_pkg::CMD_BITS))
                         && (bit_cnt_reg < sesf_pkg::CNT_W'(sesf_pkg::FRAME_BITS - 1));
    assign frame_ok    = bit_cnt_reg == sesf_pkg::CNT_W'(sesf_pkg::FRAME_BITS);
    assign status_read = cs_rise && frame_ok && !rx_reg[sesf_pkg::FRAME_BITS-1]
                         && (rx_reg[sesf_pkg::FRAME_BITS-2 -: sesf_pkg::ADDR_W] == sesf_pkg::OFS_STATUS);
    assign read_clr    = status_read ? snap_reg : '0; // R9 R10
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_reg <= '0;
            rx_reg      <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise) begin
            rx_reg      <= {rx_reg[sesf_pkg::FRAME_BITS-2:0], si_bit};
            bit_cnt_reg <= (bit_cnt_reg == sesf_pkg::CNT_MAX) ? bit_cnt_reg : bit_cnt_reg + 1'b1;
        end
    end
    // Snapshot marks exactly which flags the host was shown
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_reg   <= '0;
            snap_reg <= '0;
        end else if (cmd_load) begin
            tx_reg   <= rd_mux(cmd_addr, flag_bus.flags, ck_result_reg);
            snap_reg <= (cmd_addr == sesf_pkg::OFS_STATUS && !rx_reg[sesf_pkg::ADDR_W-1])
                        ? flag_bus.flags : '0;
        end else if (tx_shift) begin
            tx_reg   <= {tx_reg[sesf_pkg::REG_W-2:0], 1'b0};
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_so    <= 1'b0;
            o_so_oe <= 1'b0;
        end else begin
            o_so_oe <= cs_low;
            if (tx_shift) begin
                o_so <= tx_reg[sesf_pkg::REG_W-1];
            end
        end
    end

    // ------------------------------------------------------------
    // Supply windows and condition edges
    // ------------------------------------------------------------
    logic [1:0] win0_now;
    logic [1:0] win1_now;
    logic [1:0] win0_prev_reg;
    logic [1:0] win1_prev_reg;
    logic       meas_prev_reg;
    logic       win0_set;
    logic       win1_set;
    assign win0_now = thr_state(i_supply_level, i_window0_threshold_a, i_window0_threshold_b);
    assign win1_now = thr_state(i_supply_level, i_window1_threshold_a, i_window1_threshold_b);
    assign win0_set = i_meas_active && meas_prev_reg && (win0_now != win0_prev_reg); // R2
    assign win1_set = i_meas_active && meas_prev_reg && (win1_now != win1_prev_reg); // R1
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            win0_prev_reg <= '0;
            win1_prev_reg <= '0;
            meas_prev_reg <= 1'b0;
        end else begin
            win0_prev_reg <= win0_now;
            win1_prev_reg <= win1_now;
            meas_prev_reg <= i_meas_active;
        end
    end
    // Both edges of each condition count as an event
    logic low_set;
    logic high_set;
    logic tw_set;
    assign low_set  = s2_reg[sesf_pkg::P_LOW]  ^ s3_reg[sesf_pkg::P_LOW];  // R6
    assign high_set = s2_reg[sesf_pkg::P_HIGH] ^ s3_reg[sesf_pkg::P_HIGH]; // R7
    assign tw_set   = s2_reg[sesf_pkg::P_TW]   ^ s3_reg[sesf_pkg::P_TW];   // R8

    // ------------------------------------------------------------
    // Checksum engine
    // ------------------------------------------------------------
    sesf_pkg::sesf_ck_state_t ck_state_reg;
    logic [sesf_pkg::CK_W-1:0] ck_crc_reg;
    logic [sesf_pkg::CK_W-1:0] ck_crc_next;
    logic [31:0]               ck_data_reg;
    logic [5:0]                ck_cnt_reg;
    logic                      ck_busy;
    logic                      ck_last;
    logic                      ck_begin;
    assign ck_busy     = ck_state_reg == sesf_pkg::SESF_CK_RUN;
    assign ck_last     = ck_busy && (ck_cnt_reg == 6'(sesf_pkg::CK_LEN - 1));
    assign ck_begin    = i_checksum_start && !ck_busy;
    assign ck_crc_next = {ck_crc_reg[sesf_pkg::CK_W-2:0], 1'b0}
                         ^ ((ck_crc_reg[sesf_pkg::CK_W-1] ^ ck_data_reg[31]) ? sesf_pkg::CK_POLY : '0);
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ck_state_reg <= sesf_pkg::SESF_CK_IDLE;
        end else begin
            case (ck_state_reg)
                sesf_pkg::SESF_CK_IDLE: if (ck_begin) ck_state_reg <= sesf_pkg::SESF_CK_RUN;
                sesf_pkg::SESF_CK_RUN:  if (ck_last)  ck_state_reg <= sesf_pkg::SESF_CK_IDLE;
                default:                ck_state_reg <= sesf_pkg::SESF_CK_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ck_crc_reg    <= sesf_pkg::CK_INIT;
            ck_data_reg   <= '0;
            ck_cnt_reg    <= '0;
            ck_result_reg <= '0;
        end else if (ck_begin) begin
            ck_crc_reg    <= sesf_pkg::CK_INIT;
            ck_data_reg   <= i_checksum_word;
            ck_cnt_reg    <= '0;
        end else if (ck_busy) begin
            ck_crc_reg    <= ck_crc_next;
            ck_data_reg   <= {ck_data_reg[30:0], 1'b0};
            ck_cnt_reg    <= ck_cnt_reg + 1'b1;
            if (ck_last) begin
                ck_result_reg <= ck_crc_next; // R5
            end
        end
    end

    // ------------------------------------------------------------
    // Flag events and interrupt
    // ------------------------------------------------------------
    logic [sesf_pkg::FLAG_N-1:0] ck_clr;
    assign ck_clr       = ck_begin ? sesf_pkg::FLAG_N'(1 << sesf_pkg::F_CK) : '0; // R4
    assign flag_bus.clr = read_clr | ck_clr;
    assign flag_bus.set = {win1_set, win0_set, ck_last, low_set, high_set, tw_set}; // R3
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= ~|flag_bus.flags; // R10 R11
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int CK_DONE_DLY = sesf_pkg::CK_LEN;
    win1_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R1
        win1_set |=> flag_bus.flags[sesf_pkg::F_WIN1]) else $error("window 1 change missed");
    win0_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R2
        i_meas_active && meas_prev_reg && (win0_now != win0_prev_reg)
        |=> flag_bus.flags[sesf_pkg::F_WIN0]) else $error("window 0 change missed");
    ck_done_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R3
        ck_begin |=> ##CK_DONE_DLY flag_bus.flags[sesf_pkg::F_CK]) else $error("checksum done late");
    ck_running_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R4
        ck_busy |-> !flag_bus.flags[sesf_pkg::F_CK]) else $error("checksum flag while running");
    ck_result_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R5
        ck_last |=> ck_result_reg == $past(ck_crc_next)) else $error("checksum result stale");
    low_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R6
        $changed(s3_reg[sesf_pkg::P_LOW]) |-> flag_bus.flags[sesf_pkg::F_LOW]) else $error("low edge missed");
    high_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R7
        $changed(s3_reg[sesf_pkg::P_HIGH]) |-> flag_bus.flags[sesf_pkg::F_HIGH]) else $error("high edge missed");
    warn_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R8
        $changed(s3_reg[sesf_pkg::P_TW]) |-> flag_bus.flags[sesf_pkg::F_TW]) else $error("warn edge missed");
    int_release_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R10
        status_read && (flag_bus.set == '0) && (snap_reg == flag_bus.flags) |=> ##1 o_int_n)
        else $error("interrupt not released");
    int_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R11
        (flag_bus.flags != '0) |=> !o_int_n) else $error("interrupt not asserted");
    status_read_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) status_read && snap_reg != '0);
    ck_finish_c:   cover property (@(posedge i_sys_clk) disable iff (i_rst) ck_last);
    win_change_c:  cover property (@(posedge i_sys_clk) disable iff (i_rst) win0_set && win1_set);
    set_clear_c:   cover property (@(posedge i_sys_clk) disable iff (i_rst) (flag_bus.set & read_clr) != '0);
endmodule : sesf_core

`default_nettype wire

/* testbench/sesf_host_model.sv */
// Purpose: Host serial master reading the status words
// Assumes: Serial clock halves of four system clocks, idle low
// Notes:   Data line toggles once released so stale values never pass
`default_nettype none

module sesf_host_model (
    // Clock
    input  wire logic i_sys_clk,
    // Serial port
    input  wire logic i_so,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_si
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si   = 1'b0;
    end

    // Whole 32-bit frame, read data sampled before each rise
    task automatic xfer(input logic [6:0] cmd, output logic [23:0] rd);
        logic [31:0] w;
        w  = {cmd, 25'h0};
        rd = 24'h0;
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        for (int i = 31; i >= 0; i--) begin
            o_si   <= w[i];
            o_sclk <= 1'b0;
            repeat (3) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            if (i >= 1 && i <= 24) begin
                rd[i-1] = i_so;
            end
            @(posedge i_sys_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_sys_clk);
        end
        o_sclk <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        o_cs_n <= 1'b1;
        o_si   <= ~o_si;
        repeat (8) @(posedge i_sys_clk);
    endtask : xfer
endmodule : sesf_host_model

`default_nettype wire

/* testbench/tb_supply_event_status_flags.sv */
// Purpose: Self-checking bench of the supply event status flags
// Assumes: Condition pins held low through reset
// Notes:   All reads go through the host model
`default_nettype none

module tb_supply_event_status_flags;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_sys_clk;
    logic        i_rst;
    logic        cs_n;
    logic        sclk;
    logic        si;
    logic        so;
    logic        so_oe;
    logic        meas;
    logic [2:0]  cond;
    logic        ck_start;
    logic [31:0] ck_word;
    logic        int_n;
    logic [9:0]  lvl;
    int          errors;
    int          n_tests;

    sesf_core #(.LVL_W(10)) DUT (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_meas_active(meas), .i_supply_level(lvl),
        .i_window0_threshold_a(10'h100), .i_window0_threshold_b(10'h200),
        .i_window1_threshold_a(10'h300), .i_window1_threshold_b(10'h380),
        .i_supply_low(cond[2]), .i_supply_high(cond[1]), .i_thermal_warn(cond[0]),
        .i_checksum_start(ck_start), .i_checksum_word(ck_word), .o_int_n(int_n)
    );

    sesf_host_model u_host (
        .i_sys_clk(i_sys_clk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si)
    );

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_int(input logic exp);
        @(negedge i_sys_clk);
        chk("int_n", {23'h0, exp}, {23'h0, int_n});
    endtask : chk_int

    task automatic rd_chk(input string name, input logic [5:0] ofs, input logic [23:0] exp);
        logic [23:0] d;
        u_host.xfer({1'b0, ofs}, d);
        chk(name, exp, d);
    endtask : rd_chk

    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        c = sesf_pkg::CK_INIT;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? sesf_pkg::CK_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    task automatic summarize;
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_int(1'b1);
        chk("so_oe", 24'h0, {23'h0, so_oe});
        rd_chk("status", sesf_pkg::OFS_STATUS, 24'h0);
        rd_chk("unmapped", 6'h10, 24'h0);
    endtask : t_reset

    task automatic t_pins;
        for (int p = 0; p < 3; p++) begin
            cond[p] <= 1'b1;
            repeat (10) @(posedge i_sys_clk);
            chk_int(1'b0);
            rd_chk("start", sesf_pkg::OFS_STATUS, 24'h20 << p);
            chk_int(1'b1);
            rd_chk("cleared", sesf_pkg::OFS_STATUS, 24'h0);
            @(posedge i_sys_clk);
            cond[p] <= 1'b0;
            repeat (10) @(posedge i_sys_clk);
            rd_chk("end", sesf_pkg::OFS_STATUS, 24'h20 << p);
        end
    endtask : t_pins

    task automatic t_ck;
        @(posedge i_sys_clk);
        ck_start <= 1'b1;
        @(posedge i_sys_clk);
        ck_start <= 1'b0;
        repeat (20) @(posedge i_sys_clk);
        chk_int(1'b1);
        repeat (20) @(posedge i_sys_clk);
        chk_int(1'b0);
        rd_chk("ck_done", sesf_pkg::OFS_STATUS, 24'h100);
        rd_chk("ck_result", sesf_pkg::OFS_CHECKSUM, {16'h0, crc8(32'h1234_5678)});
        rd_chk("ck_ack", sesf_pkg::OFS_STATUS, 24'h0);
    endtask : t_ck

    task automatic t_win;
        lvl <= 10'h180;
        repeat (5) @(posedge i_sys_clk);
        rd_chk("win0", sesf_pkg::OFS_STATUS, 24'h200);
        lvl <= 10'h340;
        repeat (5) @(posedge i_sys_clk);
        // Level also crosses window-0 threshold b
        rd_chk("win1_a", sesf_pkg::OFS_STATUS, 24'h600);
        lvl <= 10'h390;
        repeat (5) @(posedge i_sys_clk);
        rd_chk("win1_b", sesf_pkg::OFS_STATUS, 24'h400);
        meas <= 1'b0;
        lvl  <= 10'h080;
        repeat (5) @(posedge i_sys_clk);
        rd_chk("win_off", sesf_pkg::OFS_STATUS, 24'h0);
    endtask : t_win

    // ------------------------------------------------------------
    // Clock, main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        errors   = 0;
        n_tests  = 0;
        i_rst    = 1'b1;
        meas     = 1'b1;
        cond     = 3'h0;
        ck_start = 1'b0;
        ck_word  = 32'h1234_5678;
        lvl      = 10'h080;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        t_reset();
        t_pins();
        t_ck();
        t_win();
        summarize();
    end

    initial begin
        repeat (50000) @(posedge i_sys_clk);
        errors++;
        summarize();
    end
endmodule : tb_supply_event_status_flags

`default_nettype wire
